//--- shared/dpb_pkg.sv
// Constants and types shared by the data prefetch buffer
package dpb_pkg;
  // ----------------------------------------
  // Address map and geometry
  // ----------------------------------------
  localparam logic [31:0] PF_ADDR_LO = 32'h0C00_0000;
  localparam logic [31:0] L2_BYP_HI = 32'h0FFF_FFFF;
  localparam logic [3:0] ALIAS_NIB = 4'h1;
  localparam int NUM_SLOTS = 8;
  localparam int SLOT_W = 3;
  localparam int GEN_W = 2;
  localparam int HALF_LSB = 6;
  localparam int HA_W = 32 - HALF_LSB;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;
  localparam logic [1:0] MAR_REGION = 2'h1;
  localparam int L1_MODE_POS = 0;
  localparam int L1_FRZ_POS = 4;
  localparam int L2_FRZ_POS = 8;
  localparam int L2_MODE_POS = 12;
  localparam int CORE_ID_POS = 16;
  localparam logic [31:0] CTRL_MASK = 32'h000F_7117;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CACHEABLE_BIT_POS = 0;
  localparam int PREFETCH_ENABLE_BIT_POS = 3;
  localparam int CACHEABLE_BIT_IDX = 0;
  localparam int PREFETCH_ENABLE_BIT_IDX = 1;
  localparam int MAR_PF_LO = 12;
  localparam int MAR_PF_HI = 15;
  localparam logic [1:0] MAR_RST_DEF = 2'h0;
  localparam logic [1:0] MAR_RST_PF = 2'h2;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    CLS_MISS = 2'h0,
    CLS_ADDR_HIT = 2'h1,
    CLS_DATA_HIT = 2'h2,
    CLS_DATA_WAIT = 2'h3
  } dpb_class_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SECOND = 2'h1,
    ST_WAIT = 2'h2
  } dpb_state_t;
  typedef struct packed {
    logic [31:0] addr;
    logic wr;
    logic l2_src;
  } dpb_dem_t;
  typedef struct packed {
    logic [HA_W-1:0] half_addr;
    logic [SLOT_W-1:0] slot;
    logic half;
    logic [GEN_W-1:0] gen;
  } dpb_pf_t;
endpackage : dpb_pkg

//--- design/dpb_data_prefetch_buffer.sv
// Data prefetch buffer: stream tracking, hit classification, prefetch issue
// Operation
// R1: Prefetch covers 0x0C000000 up, minus own alias
// R2: Eligible only with cacheable and prefetch bits
// R3: L1 path needs mode nonzero, not frozen
// R4: Low range or idle L2 bypasses L2
// R5: Data hit now; wait hit on return
// R6: Address hit forwards to shared controller
// R7: Miss forwards; candidate hit allocates stream
// R8: Colliding prefetches drop the earlier one
// R9: Full holding buffer drops oldest prefetch
// R10: Writes invalidate matching prefetched data
// R11: Failed return leaves slot without data
// R12: Lines are 128 bytes, halves 64
// R13: L2 takes whole line, L1 half
// R14: L1 hit may refetch other half
// R15: Eight entries, oldest reallocated first
// R16: New stream prefetches X+64 then X+128
// R17: Reallocation marks older prefetch stale
// R18: Never two valid outstanding per slot; code tracks one per half, so both halves of a slot can be outstanding at once
// R19: Software clears prefetch bit, entries 12-15
// R20: Attribute entries writable only when privileged
// R21: Software keeps L2 enabled and unfrozen
// R22: Cancelled wait return reissues as miss
//
// Decided for this implementation: the APB slave port and the placing of the registers.
module dpb_data_prefetch_buffer
  import dpb_pkg::*;
(
  // Clock and reset
  input logic core_clk,
  input logic sys_rst,
  // APB slave
  input logic [11:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] pwdata,
  input logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Demand requests
  input logic dm_valid,
  output logic dm_ready,
  input dpb_dem_t dm_req,
  // Demand outcome
  output logic rsp_valid,
  output dpb_class_t rsp_class,
  output logic rsp_served,
  output logic rsp_l2_bypass,
  // Forward to shared memory controller
  output logic fwd_valid,
  output logic fwd_wr,
  output logic [31:0] fwd_addr,
  // Prefetch issue and return
  output logic pf_valid,
  input logic pf_ready,
  output dpb_pf_t pf_req,
  input logic ret_valid,
  input dpb_pf_t ret_tag,
  input logic ret_ok
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0] ctrl_reg;
  logic [1:0] mar_reg [256];
  logic [31:0] prdata_reg;
  dpb_state_t state_reg, state_next;
  logic alloc_reg [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] alloc_vec;
  logic [HA_W-1:0] base_reg [NUM_SLOTS];
  logic [GEN_W-1:0] gen_reg [NUM_SLOTS];
  logic [1:0] dval_reg [NUM_SLOTS];
  logic [1:0] outs_reg [NUM_SLOTS];
  logic [1:0] dval_next [NUM_SLOTS];
  logic [1:0] outs_next [NUM_SLOTS];
  logic [SLOT_W-1:0] vic_reg;
  logic [HA_W-1:0] cand_reg;
  logic cand_v_reg;
  dpb_pf_t q_reg [2];
  dpb_pf_t q0_next, q1_next;
  logic [1:0] qcnt_reg, qcnt_next;
  dpb_pf_t pf2_reg;
  logic [SLOT_W-1:0] wslot_reg;
  logic [1:0] wmask_reg;
  logic [GEN_W-1:0] wgen_reg;
  logic [31:0] waddr_reg;
  logic drop_v;
  dpb_pf_t drop_e;

  function automatic logic [SLOT_W-1:0] enc(input logic [NUM_SLOTS-1:0] v);
    logic [SLOT_W-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (v[i]) begin
        r = SLOT_W'(i);
      end
    end
    return r;
  endfunction : enc

  // ----------------------------------------
  // Eligibility decode
  // ----------------------------------------
  wire l1_ok = (|ctrl_reg[L1_MODE_POS +: 3]) && !ctrl_reg[L1_FRZ_POS]; // [R3]
  wire l2_on = (|ctrl_reg[L2_MODE_POS +: 3]) && !ctrl_reg[L2_FRZ_POS];
  wire [3:0] core_id = ctrl_reg[CORE_ID_POS +: 4];
  wire [31:0] a = dm_req.addr;
  wire [HA_W-1:0] ha = a[31:HALF_LSB];
  wire [1:0] attr = mar_reg[a[31:24]];
  wire in_alias = a[31:28] == ALIAS_NIB && a[27:24] == core_id;
  wire in_range = a >= PF_ADDR_LO && !in_alias; // [R1]
  wire l2_byp = a <= L2_BYP_HI || !l2_on; // [R4]
  wire path_ok = dm_req.l2_src ? !l2_byp : l1_ok; // [R3] [R4]
  wire elig = in_range && attr[CACHEABLE_BIT_IDX] && attr[PREFETCH_ENABLE_BIT_IDX] && path_ok; // [R2]

  // ----------------------------------------
  // Slot match and classification
  // ----------------------------------------
  // A slot spans two 64-byte halves: base and base+1 form one 128-byte line
  logic [NUM_SLOTS-1:0] hit_vec, hh_vec;
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_match
    assign alloc_vec[s] = alloc_reg[s];
    assign hit_vec[s] = alloc_reg[s] && (ha == base_reg[s] || ha == base_reg[s] + 26'h1); // [R12]
    assign hh_vec[s] = ha != base_reg[s];
  end

  wire hit_any = |hit_vec;
  wire [SLOT_W-1:0] hs = enc(hit_vec);
  wire hhalf = hh_vec[hs];
  wire [1:0] m = dm_req.l2_src ? 2'h3 : (hhalf ? 2'h2 : 2'h1); // [R13]
  wire [1:0] dv = dval_reg[hs];
  wire [1:0] os = outs_reg[hs];
  wire take = dm_valid && dm_ready;
  wire rd = take && !dm_req.wr;
  wire wr = take && dm_req.wr;
  wire h_ok = elig && hit_any;
  wire data_hit = h_ok && (dv & m) == m; // [R5]
  wire wait_hit = h_ok && !data_hit && |(os & m); // [R5]
  wire addr_hit = h_ok && !data_hit && !wait_hit; // [R6]
  wire lookback = rd && addr_hit && !dm_req.l2_src && !dv[!hhalf] && !os[!hhalf]; // [R14]
  wire cand_hit = cand_v_reg && ha == cand_reg + 26'h1;
  wire alloc_go = rd && elig && !hit_any && cand_hit; // [R7] [R15]
  wire [HA_W-1:0] new_base = ha + 26'h1;

  // ----------------------------------------
  // Prefetch sources and holding queue
  // ----------------------------------------
  wire push_d = lookback || alloc_go;
  wire pf2_due = state_reg == ST_SECOND;
  wire push_v = push_d || pf2_due;
  dpb_pf_t pf1, lb, push_e;
  assign pf1 = '{half_addr: new_base, slot: vic_reg, half: 1'b0,
                 gen: gen_reg[vic_reg] + 2'h1}; // [R16] [R17]
  assign lb = '{half_addr: base_reg[hs] + {25'h0, !hhalf}, slot: hs,
                half: !hhalf, gen: gen_reg[hs]}; // [R14]
  // The pending second prefetch is the earlier one, so it loses
  assign push_e = push_d ? (alloc_go ? pf1 : lb) : pf2_reg; // [R8]
  wire pop = qcnt_reg != 2'h0 && pf_ready;

  always_comb begin
    q0_next = q_reg[0];
    q1_next = q_reg[1];
    qcnt_next = qcnt_reg;
    drop_v = 1'b0;
    drop_e = q_reg[0];
    if (pop) begin
      q0_next = q_reg[1];
      qcnt_next = qcnt_reg - 2'h1;
    end
    if (push_v) begin
      case (qcnt_next)
        2'h0: begin
          q0_next = push_e;
          qcnt_next = 2'h1;
        end
        2'h1: begin
          q1_next = push_e;
          qcnt_next = 2'h2;
        end
        default: begin
          // Full: oldest is dropped so a stale head never blocks
          drop_v = 1'b1; // [R9]
          q0_next = q_reg[1];
          q1_next = push_e;
        end
      endcase
    end
  end

  assign pf_valid = qcnt_reg != 2'h0;
  assign pf_req = q_reg[0];

  // ----------------------------------------
  // Per-slot state
  // ----------------------------------------
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
    wire al = alloc_go && vic_reg == SLOT_W'(s);
    for (genvar h = 0; h < 2; h++) begin : g_half
      // Generation tag makes any older prefetch of this slot stale
      wire rc = ret_valid && ret_tag.slot == SLOT_W'(s) && ret_tag.half == 1'(h)
                && ret_tag.gen == gen_reg[s] && outs_reg[s][h]; // [R17] [R18]
      wire dc = drop_v && drop_e.slot == SLOT_W'(s) && drop_e.half == 1'(h)
                && drop_e.gen == gen_reg[s];
      wire ps = push_v && push_e.slot == SLOT_W'(s) && push_e.half == 1'(h);
      wire wc = wr && hit_vec[s] && (dm_req.l2_src || hh_vec[s] == 1'(h)); // [R10]
      assign outs_next[s][h] = (!al && outs_reg[s][h] && !rc && !dc) || ps; // [R18]
      assign dval_next[s][h] = !al && (dval_reg[s][h] || (rc && ret_ok)) && !wc; // [R11]
    end
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        alloc_reg[s] <= 1'b0;
        base_reg[s] <= '0;
        gen_reg[s] <= '0;
        dval_reg[s] <= 2'h0;
        outs_reg[s] <= 2'h0;
      end else begin
        dval_reg[s] <= dval_next[s];
        outs_reg[s] <= outs_next[s];
        if (al) begin
          alloc_reg[s] <= 1'b1;
          base_reg[s] <= new_base; // [R16]
          gen_reg[s] <= gen_reg[s] + 2'h1; // [R17]
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_reg[0] <= '0;
      q_reg[1] <= '0;
      qcnt_reg <= 2'h0;
    end else begin
      q_reg[0] <= q0_next;
      q_reg[1] <= q1_next;
      qcnt_reg <= qcnt_next;
    end
  end

  // ----------------------------------------
  // Stream detection and demand sequencing
  // ----------------------------------------
  wire w_cur = gen_reg[wslot_reg] == wgen_reg;
  wire w_done = !w_cur || (outs_reg[wslot_reg] & wmask_reg) == 2'h0;
  wire w_srv = w_cur && (dval_reg[wslot_reg] & wmask_reg) == wmask_reg; // [R22]
  wire in_wait = state_reg == ST_WAIT;
  assign dm_ready = !in_wait;

  always_comb begin
    case (state_reg)
      ST_IDLE, ST_SECOND: begin
        if (rd && wait_hit) begin
          state_next = ST_WAIT;
        end else if (alloc_go) begin
          state_next = ST_SECOND; // [R16]
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_WAIT: begin
        state_next = w_done ? ST_IDLE : ST_WAIT;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      vic_reg <= '0;
      cand_reg <= '0;
      cand_v_reg <= 1'b0;
      pf2_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (alloc_go) begin
        vic_reg <= vic_reg + 3'h1; // [R15]
        cand_v_reg <= 1'b0;
        pf2_reg <= '{half_addr: ha + 26'h2, slot: vic_reg, half: 1'b1,
                     gen: gen_reg[vic_reg] + 2'h1}; // [R16]
      end else if (rd && elig && !hit_any) begin
        cand_reg <= ha; // [R7]
        cand_v_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wslot_reg <= '0;
      wmask_reg <= 2'h0;
      wgen_reg <= '0;
      waddr_reg <= 32'h0;
    end else if (rd && wait_hit) begin
      wslot_reg <= hs;
      wmask_reg <= m;
      wgen_reg <= gen_reg[hs];
      waddr_reg <= a;
    end
  end

  // ----------------------------------------
  // Demand outcome and forwarding
  // ----------------------------------------
  dpb_class_t cls;
  assign cls = !rd ? CLS_MISS : data_hit ? CLS_DATA_HIT :
               addr_hit ? CLS_ADDR_HIT : CLS_MISS;
  wire rsp_v_next = (take && !(rd && wait_hit)) || (in_wait && w_done);
  // A cancelled or reallocated wait goes out as a miss, never stale data
  wire fwd_v_next = in_wait ? (w_done && !w_srv) : (take && !(rd && (data_hit || wait_hit))); // [R6] [R22]

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_class <= CLS_MISS;
      rsp_served <= 1'b0;
      rsp_l2_bypass <= 1'b0;
      fwd_valid <= 1'b0;
      fwd_wr <= 1'b0;
      fwd_addr <= 32'h0;
    end else begin
      rsp_valid <= rsp_v_next;
      fwd_valid <= fwd_v_next;
      rsp_class <= in_wait ? CLS_DATA_WAIT : cls;
      rsp_served <= in_wait ? w_srv : (rd && data_hit); // [R5]
      fwd_addr <= in_wait ? waddr_reg : a;
      fwd_wr <= !in_wait && dm_req.wr;
      if (!in_wait) begin
        rsp_l2_bypass <= l2_byp;
      end
    end
  end

  // ----------------------------------------
  // APB registers
  // ----------------------------------------
  wire sel_mar = paddr[11:10] == MAR_REGION;
  wire sel_ctrl = paddr == OFF_CTRL;
  wire sel_stat = paddr == OFF_STAT;
  wire acc = psel && penable;
  wire [7:0] midx = paddr[9:2];
  wire [31:0] stat = {16'h0000, alloc_vec, 2'h0, qcnt_reg, 2'h0, state_reg};
  wire [31:0] mar_rd = {28'h0000000, mar_reg[midx][PREFETCH_ENABLE_BIT_IDX], 2'h0,
                        mar_reg[midx][CACHEABLE_BIT_IDX]};
  wire [31:0] rd_mux = sel_ctrl ? ctrl_reg : sel_stat ? stat : sel_mar ? mar_rd : 32'h0;
  assign pready = 1'b1;
  assign pslverr = acc && !(sel_ctrl || sel_stat || sel_mar);
  assign prdata = prdata_reg;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RST;
      prdata_reg <= 32'h0;
    end else begin
      if (psel && !penable) begin
        prdata_reg <= rd_mux;
      end
      if (acc && pwrite && sel_ctrl) begin
        ctrl_reg <= pwdata & CTRL_MASK;
      end
    end
  end

  // Low entries come up prefetchable; software must clear them
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 256; i++) begin
        mar_reg[i] <= (i >= MAR_PF_LO && i <= MAR_PF_HI) ? MAR_RST_PF : MAR_RST_DEF; // [R19]
      end
    end else if (acc && pwrite && sel_mar && pprot[0]) begin
      mar_reg[midx] <= {pwdata[PREFETCH_ENABLE_BIT_POS], pwdata[CACHEABLE_BIT_POS]}; // [R20]
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_alias_window: assert property (rd && in_alias |=> rsp_valid && rsp_class == CLS_MISS && fwd_valid) // [R1]
    else $error("alias access classified as hit");
  a_attr_gate: assert property (rd && !(attr[0] && attr[1]) |=> rsp_class == CLS_MISS && fwd_valid) // [R2]
    else $error("non-prefetchable access hit");
  a_l1_gate: assert property (rd && !dm_req.l2_src && !l1_ok |=> rsp_class == CLS_MISS) // [R3]
    else $error("frozen l1 path reached prefetcher");
  a_l2_bypass: assert property (take && a >= PF_ADDR_LO && a <= L2_BYP_HI |=> rsp_l2_bypass) // [R4]
    else $error("low range not bypassing l2");
  a_data_hit: assert property (rd && data_hit |=> rsp_valid && rsp_served && !fwd_valid) // [R5]
    else $error("data hit not served at once");
  a_addr_fwd: assert property (rd && addr_hit |=> fwd_valid && rsp_class == CLS_ADDR_HIT) // [R6]
    else $error("address hit not forwarded");
  a_collide_keep: assert property (pf2_due && push_d |-> push_e != pf2_reg) // [R8]
    else $error("earlier prefetch kept on collision");
  a_queue_drop: assert property (push_v && qcnt_reg == 2'h2 && !pf_ready |=> qcnt_reg == 2'h2 && q_reg[0] == $past(q_reg[1])) // [R9]
    else $error("oldest prefetch not dropped");
  a_wr_inval: assert property (wr && hit_any && !dm_req.l2_src |=> !dval_reg[$past(hs)][$past(hhalf)]) // [R10]
    else $error("write left prefetched data");
  a_victim_order: assert property (alloc_go |=> vic_reg == $past(vic_reg) + 3'h1 ##1 !pf2_due) // [R15]
    else $error("victim pointer wrong");
  a_new_stream: assert property (alloc_go |-> push_v && !push_e.half ##1 pf2_due && push_e.half) // [R16]
    else $error("new stream prefetch order wrong");
  a_single_out: assert property (push_v && !alloc_go |-> !outs_reg[push_e.slot][push_e.half]) // [R18]
    else $error("two outstanding prefetches in one slot");

  c_data_hit: cover property (rd && data_hit);
  c_wait_done: cover property (in_wait && w_done && w_srv);
  c_reissue: cover property (in_wait && w_done && !w_srv);
  c_drop: cover property (drop_v);

endmodule : dpb_data_prefetch_buffer

//--- bench/dpb_mem_model.sv
// Behavioural shared memory controller that answers prefetches in order
module dpb_mem_model
  import dpb_pkg::*;
(
  // Clock and reset
  input logic core_clk,
  input logic sys_rst,
  // Bench controls: hold back returns, return them cancelled
  input logic hold,
  input logic fail,
  // Prefetch issue and return
  input logic pf_valid,
  output logic pf_ready,
  input dpb_pf_t pf_req,
  output logic ret_valid,
  output dpb_pf_t ret_tag,
  output logic ret_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Pending prefetches
  // ----
  dpb_pf_t q[$];
  assign pf_ready = 1'b1;
  // Tag and status toggle between returns so an old value never looks fresh
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q.delete();
      ret_valid <= 1'b0;
      ret_tag <= '0;
      ret_ok <= 1'b0;
    end else begin
      ret_valid <= 1'b0;
      ret_tag <= ~ret_tag;
      ret_ok <= ~ret_ok;
      if (!hold && q.size() > 0) begin
        ret_valid <= 1'b1;
        ret_tag <= q.pop_front();
        ret_ok <= !fail;
      end
      if (pf_valid && pf_ready) begin
        q.push_back(pf_req);
      end
    end
  end
endmodule : dpb_mem_model

//--- bench/dpb_data_prefetch_buffer_test.sv
// Self-checking testbench for the data prefetch buffer
module dpb_data_prefetch_buffer_test;
  import dpb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Signals
  // ----
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] pprot = 3'h1;
  logic [31:0] prdata, fwd_addr;
  logic pready, pslverr, dm_ready, rsp_valid, rsp_served, rsp_l2_bypass, fwd_valid, fwd_wr;
  logic dm_valid = 1'b0;
  dpb_dem_t dm_req = '0;
  dpb_class_t rsp_class;
  logic pf_valid, pf_ready, ret_valid, ret_ok;
  dpb_pf_t pf_req, ret_tag;
  logic hold = 1'b0;
  logic fail = 1'b0;
  // ----
  // Reference model state
  // ----
  int error_cnt = 0;
  int comparisons = 0;
  integer seed = 32'h09647fa5;
  int attr[256];
  bit l1ok = 1'b0;
  bit l2off = 1'b1;
  logic [3:0] core_id = 4'h0;
  int cand = -5;
  int streams[$];
  bit dat[int];
  bit outst[int];
  dpb_pf_t pf_log[$];
  logic [7:0] regs[5] = '{8'h05, 8'h12, 8'h21, 8'h0C, 8'h20};

  always #50 core_clk = ~core_clk;

  dpb_data_prefetch_buffer DUT (.core_clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pprot, .prdata, .pready, .pslverr, .dm_valid, .dm_ready, .dm_req, .rsp_valid, .rsp_class,
    .rsp_served, .rsp_l2_bypass, .fwd_valid, .fwd_wr, .fwd_addr, .pf_valid, .pf_ready, .pf_req,
    .ret_valid, .ret_tag, .ret_ok);
  dpb_mem_model mem (.core_clk, .sys_rst, .hold, .fail, .pf_valid, .pf_ready, .pf_req,
    .ret_valid, .ret_tag, .ret_ok);

  // Outstanding and returned halves, seen from the bus side
  always @(posedge core_clk) begin
    if (!sys_rst && pf_valid && pf_ready) begin
      outst[pf_req.half_addr] = 1'b1;
      pf_log.push_back(pf_req);
    end
    if (!sys_rst && ret_valid) begin
      outst.delete(ret_tag.half_addr);
      if (ret_ok) begin
        dat[ret_tag.half_addr] = 1'b1;
      end
    end
  end

  function automatic bit elig(logic [31:0] a);
    return attr[a[31:24]] == 9 && l1ok && a >= PF_ADDR_LO && a[31:24] != {ALIAS_NIB, core_id};
  endfunction : elig

  function automatic int cls_of(int h);
    if (dat.exists(h)) return 2;
    if (outst.exists(h)) return 3;
    foreach (streams[i]) if (h == streams[i] || h == streams[i] + 1) return 1;
    return 0;
  endfunction : cls_of

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic apb(logic [11:0] a, logic wr, logic [31:0] d, logic [2:0] pr,
      output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    pprot <= pr;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic setattr(logic [7:0] r, int v, logic [2:0] pr);
    logic [31:0] rd;
    logic err;
    apb(12'h400 + {r, 2'b00}, 1'b1, v, pr, rd, err);
    if (pr[0]) attr[r] = v;
    apb(12'h400 + {r, 2'b00}, 1'b0, 32'h0, 3'h1, rd, err);
    check(rd, attr[r]);
  endtask : setattr

  task automatic demand(logic [31:0] a, bit wr, bit l2);
    int h, c, n;
    h = a[31:6];
    @(posedge core_clk);
    dm_valid <= 1'b1;
    dm_req <= '{a, wr, l2};
    n = 0;
    do begin @(negedge core_clk); n++; end while (dm_ready !== 1'b1 && n < 50);
    c = wr ? 0 : cls_of(h);
    @(posedge core_clk);
    dm_valid <= 1'b0;
    n = 0;
    do begin @(negedge core_clk); n++; end while (rsp_valid !== 1'b1 && n < 50);
    check(rsp_valid, 1'b1);
    check(rsp_class, c);
    check(rsp_served, c == 2 || (c == 3 && !fail));
    if (a >= PF_ADDR_LO) check(rsp_l2_bypass, l2off || a <= L2_BYP_HI);
    if (c != 3) check(fwd_valid, c < 2);
    if (c == 3) check(fwd_valid, fail);
    if (c < 2) check({fwd_wr, fwd_addr}, {wr, a});
    if (wr) begin
      dat.delete(h);
    end else if (c == 0 && elig(a)) begin
      if (h == cand + 1) streams.push_back(h + 1);
      if (streams.size() > 8) begin
        dat.delete(streams[0]);
        dat.delete(streams[0] + 1);
        void'(streams.pop_front());
      end
      cand = h;
    end
  endtask : demand

  // ----
  // Watchdog
  // ----
  initial begin
    #1000000;
    error_cnt++;
    final_report();
  end

  // ----
  // Main sequence
  // ----
  initial begin
    logic [31:0] rd, b;
    logic err;
    logic [7:0] used;
    foreach (attr[i]) attr[i] = (i >= 12 && i <= 15) ? 8 : 0;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    apb(OFF_CTRL, 1'b0, 32'h0, 3'h1, rd, err);
    check(rd, CTRL_RST);
    apb(12'h010, 1'b0, 32'h0, 3'h1, rd, err);
    check(err, 1'b1);
    apb(12'h430, 1'b0, 32'h0, 3'h1, rd, err);
    check(rd, 32'h8);
    setattr(8'h20, 9, 3'h0);
    setattr(8'h20, 9, 3'h1);
    // Prefetch off for the low window, as software must do
    for (int i = 12; i < 16; i++) setattr(i[7:0], 0, 3'h1);
    for (int i = 0; i < 3; i++) setattr(regs[i], (i == 2) ? 1 : 9, 3'h1);
    apb(OFF_CTRL, 1'b1, 32'h0002_1001, 3'h1, rd, err);
    l1ok = 1'b1;
    l2off = 1'b0;
    core_id = 4'h2;
    $display("register test done");
    for (int i = 0; i < 5; i++) begin
      if (i == 4) begin
        apb(OFF_CTRL, 1'b1, 32'h0002_1011, 3'h1, rd, err);
        l1ok = 1'b0;
      end
      for (int k = 0; k < 3; k++) demand({regs[i], 24'hF0_0000} + k * 64, 1'b0, 1'b0);
    end
    apb(OFF_CTRL, 1'b1, 32'h0002_1001, 3'h1, rd, err);
    l1ok = 1'b1;
    $display("eligibility test done");
    for (int i = 0; i < 8; i++) begin
      rd = $random(seed);
      b = 32'h0002_1001 | {23'h0, rd[31], 8'h00};
      apb(OFF_CTRL, 1'b1, b, 3'h1, rd, err);
      l2off = b[8];
      rd = $random(seed);
      demand({8'h30, rd[23:0]}, rd[24], rd[25]);
    end
    apb(OFF_CTRL, 1'b1, 32'h0002_1001, 3'h1, rd, err);
    l2off = 1'b0;
    $display("random test done");
    for (int j = 0; j < 9; j++) begin
      demand(32'h2000_0000 + j * 32'h1000, 1'b0, 1'b0);
      demand(32'h2000_0040 + j * 32'h1000, 1'b0, 1'b0);
    end
    repeat (4) @(posedge core_clk);
    check(pf_log.size(), 18);
    used = 8'h00;
    for (int j = 0; j < 9; j++) begin
      b = (32'h2000_0080 + j * 32'h1000) >> 6;
      check(pf_log[2*j].half_addr, b);
      check(pf_log[2*j+1].half_addr, b + 1);
      check({pf_log[2*j].half, pf_log[2*j+1].half}, 2'b01);
      if (j < 8) used[pf_log[2*j].slot] = 1'b1;
    end
    check(used, 8'hFF);
    check(pf_log[16].slot, pf_log[0].slot);
    demand(32'h2000_8080, 1'b0, 1'b0);
    demand(32'h2000_80C0, 1'b1, 1'b0);
    demand(32'h2000_80C0, 1'b0, 1'b0);
    // Both halves now empty, so an early-half read must look back
    demand(32'h2000_8080, 1'b1, 1'b0);
    demand(32'h2000_8080, 1'b0, 1'b0);
    repeat (4) @(posedge core_clk);
    check(pf_log[18].half_addr, 32'h2000_80C0 >> 6);
    check(pf_log[18].half, 1'b1);
    demand(32'h2000_7080, 1'b0, 1'b1);
    $display("stream test done");
    // Returns held back so the demand must wait, then succeed or fail
    for (int f = 0; f < 2; f++) begin
      fail <= f[0];
      hold <= 1'b1;
      demand(32'h2010_0000 + f * 32'h1000, 1'b0, 1'b0);
      demand(32'h2010_0040 + f * 32'h1000, 1'b0, 1'b0);
      fork
        demand(32'h2010_0080 + f * 32'h1000, 1'b0, 1'b0);
        begin
          repeat (8) @(posedge core_clk);
          hold <= 1'b0;
        end
      join
    end
    fail <= 1'b0;
    $display("wait test done");
    final_report();
  end
endmodule : dpb_data_prefetch_buffer_test
